// File: hdl/ppm_pkg.sv
// Constants and carrier types for the PROM programmer controller.
// Assumes a 100 MHz system clock driving every timing count.
package ppm_pkg;
  localparam int          PPM_CLK_MHZ       = 100;
  localparam int          PPM_PULSE_US      = 100;
  localparam int          PPM_PULSE_CYC     = PPM_PULSE_US * PPM_CLK_MHZ;
  localparam int          PPM_SETUP_CYC     = 4;
  localparam int          PPM_MAX_TRIES     = 10;
  localparam int          PPM_ADDR_W        = 17;
  localparam int          PPM_DATA_W        = 8;
  localparam int          PPM_PAGE_BYTES    = 4;
  localparam logic [3:0]  PPM_TRIES_W4      = 4'hA;

  typedef enum logic [1:0] {
    PPM_OP_READ,
    PPM_OP_BYTE,
    PPM_OP_PAGE
  } ppm_op_type;

  typedef struct packed {
    ppm_op_type                     op;
    logic [PPM_ADDR_W-1:0]          addr;
    logic [PPM_PAGE_BYTES*PPM_DATA_W-1:0] data;
  } ppm_req_type;

  typedef struct packed {
    logic                  chip_sel_n;
    logic                  out_gate_n;
    logic                  program_strobe_n;
    logic                  data_oe;
    logic [PPM_ADDR_W-1:0] addr;
    logic [PPM_DATA_W-1:0] data;
  } ppm_pins_type;
endpackage

// File: hdl/ppm_timer.sv
// Cycle down-counter used for pin setup and program pulse widths.
// Assumes the caller loads it only while it is idle.
`timescale 1ns/10ps
module ppm_timer
  import ppm_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);
  logic [W-1:0] cnt_r;

  initial begin
    if (W < 2) $error("Timer width too small.");
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= count_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  // Done depends only on the count so that a caller may load from it.
  assign done_o = (cnt_r == '0);
endmodule

// File: hdl/ppm_host.sv
// PROM programmer controller that drives the device pins in program mode.
// Holds the device reset low itself once out of reset; assumes the programming supply is on.
`timescale 1ns/10ps
module ppm_host
  import ppm_pkg::*;
#(
  parameter int PULSE_CYC = PPM_PULSE_CYC,
  parameter int SETUP_CYC = PPM_SETUP_CYC
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  req_valid_i,
  input  wire ppm_req_type           req_i,
  output logic                       req_ready_o,
  output logic                       done_o,
  output logic                       fail_o,
  output logic [PPM_PAGE_BYTES*PPM_DATA_W-1:0] rdata_o,
  output logic                       prom_reset_n_o,
  output logic                       chip_sel_n_o,
  output logic                       out_gate_n_o,
  output logic                       program_strobe_n_o,
  output logic [PPM_ADDR_W-1:0]      prom_address_lines_o,
  output logic [PPM_DATA_W-1:0]      prom_data_lines_o,
  output logic                       prom_data_lines_oe_o,
  input  wire logic [PPM_DATA_W-1:0] prom_data_lines_i
);
  initial begin
    if (PULSE_CYC < 1 || PULSE_CYC > 65535) $error("Bad pulse count.");
    if (SETUP_CYC < 2 || SETUP_CYC > 65535) $error("Bad setup count.");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_LATCH, ST_LATCH_HOLD, ST_PULSE_SET, ST_PULSE,
    ST_VFY_SET, ST_VFY, ST_READ_ADDR, ST_READ, ST_FINISH
  } ppm_state_type;

  ////////////////////////////////////////////////////////////////////////////
  ppm_state_type         state_r;
  ppm_req_type           req_r;
  logic [1:0]            idx_r;
  logic [3:0]            tries_r;
  logic                  bad_r;
  logic [PPM_DATA_W-1:0] sync1_r;
  logic [PPM_DATA_W-1:0] sync2_r;
  ppm_pins_type          pins_r;
  logic                  tmr_load;
  logic [15:0]           tmr_count;
  logic                  tmr_done;
  logic [1:0]            last_idx;

  function automatic logic [PPM_DATA_W-1:0] byte_of(
    input logic [PPM_PAGE_BYTES*PPM_DATA_W-1:0] w, input logic [1:0] i);
    byte_of = w[i*PPM_DATA_W +: PPM_DATA_W];
  endfunction

  assign last_idx = (req_r.op == PPM_OP_PAGE) ? 2'h3 : 2'h0;

  ppm_timer #(.W(16)) u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (tmr_load),
    .count_i   (tmr_count),
    .done_o    (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input data bus passes two flip-flops before comparison.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= prom_data_lines_i;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer loads on each state entry that needs a wait.
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = 16'(SETUP_CYC);
    if (tmr_done) begin
      unique case (state_r)
        ST_IDLE: tmr_load = req_valid_i;
        ST_LATCH, ST_VFY_SET, ST_READ_ADDR: tmr_load = 1'b1;
        ST_LATCH_HOLD: tmr_load = 1'b1;
        ST_PULSE_SET: begin
          tmr_load  = 1'b1;
          tmr_count = 16'(PULSE_CYC - 1);
        end
        ST_PULSE, ST_VFY, ST_READ: tmr_load = 1'b1;
        ST_FINISH: tmr_load = bad_r && (tries_r < PPM_TRIES_W4);
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and pin drive.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      req_r   <= '0;
      idx_r   <= 2'h0;
      tries_r <= 4'h0;
      bad_r   <= 1'b0;
      rdata_o <= '0;
      done_o  <= 1'b0;
      fail_o  <= 1'b0;
      pins_r  <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1,
                   program_strobe_n: 1'b1, data_oe: 1'b0,
                   addr: '0, data: 8'h00};
    end else begin
      done_o <= 1'b0;
      if (tmr_done) begin
        unique case (state_r)
          ST_IDLE: begin
            if (req_valid_i) begin
              req_r          <= req_i;
              idx_r          <= 2'h0;
              tries_r        <= 4'h0;
              fail_o         <= 1'b0;
              pins_r.addr    <= req_i.addr;
              pins_r.program_strobe_n <= 1'b1;
              if (req_i.op == PPM_OP_READ) begin
                pins_r.chip_sel_n <= 1'b0;
                pins_r.out_gate_n <= 1'b1;
                pins_r.data_oe    <= 1'b0;
                state_r           <= ST_READ_ADDR;
              end else if (req_i.op == PPM_OP_PAGE) begin
                pins_r.chip_sel_n <= 1'b1;
                pins_r.out_gate_n <= 1'b0;
                pins_r.data_oe    <= 1'b1;
                pins_r.data       <= byte_of(req_i.data, 2'h0);
                state_r           <= ST_LATCH;
              end else begin
                pins_r.chip_sel_n <= 1'b0;
                pins_r.out_gate_n <= 1'b1;
                pins_r.data_oe    <= 1'b1;
                pins_r.data       <= byte_of(req_i.data, 2'h0);
                state_r           <= ST_PULSE_SET;
              end
            end
          end
          ST_LATCH: begin
            pins_r.data_oe <= 1'b1;
            state_r        <= ST_LATCH_HOLD;
          end
          ST_LATCH_HOLD: begin
            if (idx_r == 2'h3) begin
              pins_r.addr       <= req_r.addr;
              pins_r.out_gate_n <= 1'b1;
              pins_r.data_oe    <= 1'b0;
              idx_r             <= 2'h0;
              state_r           <= ST_PULSE_SET;
            end else begin
              idx_r       <= idx_r + 2'h1;
              pins_r.addr <= req_r.addr + PPM_ADDR_W'(idx_r + 2'h1);
              pins_r.data <= byte_of(req_r.data, idx_r + 2'h1);
              state_r     <= ST_LATCH;
            end
          end
          ST_PULSE_SET: begin
            pins_r.program_strobe_n <= 1'b0;
            tries_r                 <= tries_r + 4'h1;
            bad_r                   <= 1'b0;
            state_r                 <= ST_PULSE;
          end
          ST_PULSE: begin
            pins_r.program_strobe_n <= 1'b1;
            pins_r.data_oe          <= 1'b0;
            pins_r.chip_sel_n       <= 1'b0;
            pins_r.addr             <= req_r.addr;
            idx_r                   <= 2'h0;
            state_r                 <= ST_VFY_SET;
          end
          ST_VFY_SET: begin
            pins_r.out_gate_n <= 1'b0;
            state_r           <= ST_VFY;
          end
          ST_VFY: begin
            if (sync2_r != byte_of(req_r.data, idx_r)) bad_r <= 1'b1;
            pins_r.out_gate_n <= 1'b1;
            if (idx_r != last_idx) begin
              idx_r       <= idx_r + 2'h1;
              pins_r.addr <= req_r.addr + PPM_ADDR_W'(idx_r + 2'h1);
              state_r     <= ST_VFY_SET;
            end else begin
              state_r <= ST_FINISH;
            end
          end
          ST_READ_ADDR: begin
            pins_r.out_gate_n <= 1'b0;
            state_r           <= ST_READ;
          end
          ST_READ: begin
            rdata_o           <= {24'h000000, sync2_r};
            pins_r.out_gate_n <= 1'b1;
            pins_r.chip_sel_n <= 1'b1;
            done_o            <= 1'b1;
            state_r           <= ST_IDLE;
          end
          ST_FINISH: begin
            if (bad_r && tries_r < PPM_TRIES_W4) begin
              pins_r.data_oe <= (req_r.op != PPM_OP_PAGE);
              pins_r.addr    <= req_r.addr;
              pins_r.data    <= byte_of(req_r.data, 2'h0);
              if (req_r.op == PPM_OP_PAGE) begin
                pins_r.chip_sel_n <= 1'b1;
              end
              state_r <= ST_PULSE_SET;
            end else begin
              fail_o            <= bad_r;
              done_o            <= 1'b1;
              pins_r.chip_sel_n <= 1'b1;
              state_r           <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_ready_o    <= 1'b0;
      prom_reset_n_o <= 1'b1;
    end else begin
      req_ready_o    <= (state_r == ST_IDLE) && tmr_done && !tmr_load &&
                        !req_valid_i;
      prom_reset_n_o <= 1'b0;
    end
  end

  assign chip_sel_n_o         = pins_r.chip_sel_n;
  assign out_gate_n_o         = pins_r.out_gate_n;
  assign program_strobe_n_o   = pins_r.program_strobe_n;
  assign prom_address_lines_o = pins_r.addr;
  assign prom_data_lines_o    = pins_r.data;
  assign prom_data_lines_oe_o = pins_r.data_oe;
endmodule

// File: dv/ppm_host_checker.sv
// Checker for the PROM programmer controller's pin sequencing.
// Assumes it is bound to ppm_host and sees only that module's ports.
`timescale 1ns/10ps
module ppm_host_checker
  import ppm_pkg::*;
#(
  parameter int PULSE_CYC = PPM_PULSE_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic req_valid_i,
  input  wire logic req_ready_o,
  input  wire logic fail_o,
  input  wire logic prom_reset_n_o,
  input  wire logic chip_sel_n_o,
  input  wire logic out_gate_n_o,
  input  wire logic program_strobe_n_o,
  input  wire logic prom_data_lines_oe_o
);
  logic [15:0] low_r;
  logic [4:0]  tries_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_r <= 16'h0;
    end else begin
      low_r <= program_strobe_n_o ? 16'h0 : low_r + 16'h1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tries_r <= 5'h0;
    end else if (req_valid_i && req_ready_o) begin
      tries_r <= 5'h0;
    end else if ($fell(program_strobe_n_o)) begin
      tries_r <= tries_r + 5'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_pulse_start;
    $fell(program_strobe_n_o);
  endsequence
  sequence s_pulse_end;
    $rose(program_strobe_n_o);
  endsequence
  a_pulse_gate: assert property (
    s_pulse_start |-> out_gate_n_o) else $error("pulse with gate low");
  a_pulse_width: assert property (
    s_pulse_end |-> low_r == PULSE_CYC) else $error("pulse width wrong");
  a_page_float: assert property (
    !program_strobe_n_o && chip_sel_n_o |-> !prom_data_lines_oe_o)
    else $error("bus driven in page pulse");
  a_byte_data: assert property (
    !program_strobe_n_o && !chip_sel_n_o |-> prom_data_lines_oe_o)
    else $error("bus idle in byte pulse");
  a_verify_read: assert property (
    !out_gate_n_o && !chip_sel_n_o |->
    program_strobe_n_o && !prom_data_lines_oe_o) else $error("bad verify");
  a_latch_drive: assert property (
    !out_gate_n_o && chip_sel_n_o |->
    program_strobe_n_o && prom_data_lines_oe_o) else $error("bad latch");
  a_reset_kept: assert property (
    !prom_reset_n_o |=> !prom_reset_n_o) else $error("device reset rose");
  a_ready_prog: assert property (
    req_ready_o |-> !prom_reset_n_o) else $error("ready outside mode");
  a_tries_cap: assert property (
    tries_r <= PPM_MAX_TRIES) else $error("too many pulses");
  a_fail_last: assert property (
    $rose(fail_o) |-> tries_r == PPM_MAX_TRIES) else $error("early fail");
endmodule
bind ppm_host ppm_host_checker #(.PULSE_CYC(PULSE_CYC)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .fail_o(fail_o),
  .prom_reset_n_o(prom_reset_n_o), .chip_sel_n_o(chip_sel_n_o),
  .out_gate_n_o(out_gate_n_o), .program_strobe_n_o(program_strobe_n_o),
  .prom_data_lines_oe_o(prom_data_lines_oe_o)
);

// File: dv/ppm_prom_model.sv
// Behavioural one-time PROM in programming mode.
// Assumes the bench resolves the shared data bus and feeds it back.
`timescale 1ns/10ps
module ppm_prom_model
  import ppm_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  chip_sel_n_i,
  input  wire logic                  out_gate_n_i,
  input  wire logic                  program_strobe_n_i,
  input  wire logic [PPM_ADDR_W-1:0] addr_i,
  input  wire logic [PPM_DATA_W-1:0] bus_i,
  output logic      [PPM_DATA_W-1:0] data_o,
  output logic                       data_oe_o
);
  logic [7:0]  mem [0:131071];
  logic [7:0]  lat [0:3];
  logic [14:0] page_r;
  logic [7:0]  last_r;
  int          skip;
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
    last_r = 8'h00;
    skip = 0;
  end
  //////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    if (!reset_n_i && chip_sel_n_i && !out_gate_n_i && program_strobe_n_i) begin
      lat[addr_i[1:0]] <= bus_i;
      page_r <= addr_i[16:2];
    end
    if (data_oe_o) last_r <= data_o;
  end
  always @(negedge program_strobe_n_i) begin
    if (!reset_n_i && out_gate_n_i) begin
      if (skip > 0) begin
        skip--;
      end else if (chip_sel_n_i) begin
        for (int i = 0; i < 4; i++) mem[{page_r, 2'(i)}] = lat[i];
      end else begin
        mem[addr_i] = bus_i;
      end
    end
  end
  always_comb begin
    data_oe_o = !reset_n_i && !chip_sel_n_i && !out_gate_n_i &&
                program_strobe_n_i;
    data_o = data_oe_o ? mem[addr_i] : ~last_r;
  end
endmodule

// File: dv/ppm_host_tb.sv
// Self-checking bench for the PROM programmer controller.
// Assumes the PROM model answers on the far side of the pins.
`timescale 1ns/10ps
module ppm_host_tb
  import ppm_pkg::*;
();
  localparam int PULSE = 20;
  logic        clk, rst_n, vld, rdy, done, fail, prst_n, cs_n, og_n, pgm_n;
  logic        doe, m_oe;
  logic [16:0] addr;
  logic [7:0]  dout, m_d, bus;
  logic [31:0] rdata;
  ppm_req_type req;
  int          failures, checked, pulses;
  assign bus = doe ? dout : m_d;
  ppm_host #(.PULSE_CYC(PULSE)) i_dut (
    .sys_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(vld), .req_i(req),
    .req_ready_o(rdy), .done_o(done), .fail_o(fail), .rdata_o(rdata),
    .prom_reset_n_o(prst_n), .chip_sel_n_o(cs_n), .out_gate_n_o(og_n),
    .program_strobe_n_o(pgm_n), .prom_address_lines_o(addr),
    .prom_data_lines_o(dout), .prom_data_lines_oe_o(doe),
    .prom_data_lines_i(bus));
  ppm_prom_model i_prom (
    .sys_clk_i(clk), .reset_n_i(prst_n), .chip_sel_n_i(cs_n),
    .out_gate_n_i(og_n), .program_strobe_n_i(pgm_n), .addr_i(addr),
    .bus_i(bus), .data_o(m_d), .data_oe_o(m_oe));
  always #5 clk = ~clk;
  always @(negedge pgm_n) pulses++;
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(ppm_op_type op, logic [16:0] a, logic [31:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin @(posedge clk); #1 n++; end
    if (n >= 100) begin failures++; print_verdict(); end
    vld = 1'b1;
    req = '{op: op, addr: a, data: d};
    pulses = 0;
    @(posedge clk);
    #1 vld = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 9000) begin @(posedge clk); #1 n++; end
    if (n >= 9000) begin failures++; print_verdict(); end
  endtask
  task automatic t_blank_read();
    run(PPM_OP_READ, 17'h1FFFF, 32'h0);
    check("blank byte", 32'h000000FF, rdata);
    check("device reset", 32'h0, {31'h0, prst_n});
    $display("blank read done");
  endtask
  task automatic t_byte(int bad, logic [16:0] a, logic [7:0] d);
    i_prom.skip = bad;
    run(PPM_OP_BYTE, a, {24'h0, d});
    check("pulses", (bad < 10) ? bad + 1 : 10, pulses);
    check("fail", {31'h0, bad >= 10}, {31'h0, fail});
    run(PPM_OP_READ, a, 32'h0);
    check("byte", {24'h0, (bad < 10) ? d : 8'hFF}, rdata);
    $display("byte write done");
  endtask
  task automatic t_page(int bad, logic [16:0] a, logic [31:0] d);
    i_prom.skip = bad;
    run(PPM_OP_PAGE, a, d);
    check("page pulses", bad + 1, pulses);
    check("page fail", 32'h0, {31'h0, fail});
    for (int i = 0; i < 4; i++) begin
      run(PPM_OP_READ, a + 17'(i), 32'h0);
      check("page byte", {24'h0, d[8*i +: 8]}, rdata);
    end
    $display("page write done");
  endtask
  initial begin
    clk = 1'b0; rst_n = 1'b0; vld = 1'b0; req = '0;
    failures = 0; checked = 0; pulses = 0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    t_blank_read();
    t_byte(0, 17'h00010, 8'h5A);
    t_byte(3, 17'h00011, 8'hC3);
    t_byte(10, 17'h00012, 8'h81);
    t_page(0, 17'h00100, 32'h44332211);
    t_page(2, 17'h1FFFC, 32'hA55AF00F);
    print_verdict();
  end
endmodule
